// ===== design/module_config_defines.vh
// register offsets, field positions, reset values and constants of the configuration bank
`ifndef MODULE_CONFIG_DEFINES_VH
`define MODULE_CONFIG_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_OUTPUT_ROUTING 8'h89
`define OFS_FLAG_LATCH 8'h8A
`define OFS_DISABLE_RSSI 8'h8B
`define OFS_SLAVE_ADDRESS 8'h8C
`define OFS_RESERVED_BYTE 8'h8D
`define OFS_MON12_SHIFT 8'h8E
`define OFS_THIRD_SHIFT 8'h8F

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_OUTPUT_ROUTING 8'h80
`define RST_FLAG_LATCH 8'h00
`define RST_DISABLE_RSSI 8'h00
`define RST_SLAVE_ADDRESS 8'h00
`define RST_MON12_SHIFT 8'h00
`define RST_THIRD_SHIFT 8'h30

// ----------------------------------------
// writable bit masks (reserved bits are zero)
// ----------------------------------------
`define MASK_FLAG_LATCH 8'h27
`define MASK_SHIFT 8'h77

// ----------------------------------------
// field positions, output_routing_config
// ----------------------------------------
`define BIT_LOSS_SOURCE 7
`define BIT_SUPPLY_MASK 6
`define BIT_LOSS_INVERT 5
`define BIT_ADDR_SOURCE 4
`define BIT_ALARM_ROW 3
`define BIT_RATE_INVERT 2
`define BIT_RATE_FROM_PIN 1
`define BIT_FAULT_INVERT 0

// ----------------------------------------
// field positions, flag_latch_config
// ----------------------------------------
`define BIT_FAULT_ON_DISABLE 5
`define BIT_ALARM_LATCH 2
`define BIT_QT_LATCH 1
`define BIT_WARN_LATCH 0

// ----------------------------------------
// field positions, disable_and_rssi_config
// ----------------------------------------
`define BIT_CROSSOVER_EN 7
`define BIT_MONITOR_INPUT_TWO_REF 6
`define BIT_DISABLE_CLEARS 5
`define BIT_GATE_TO_DISABLE 4
`define BIT_FAULT_TO_DISABLE 3
`define BIT_DISABLE_IGNORE 2
`define FORCE_FINE 2'b01
`define FORCE_COARSE 2'b10

// ----------------------------------------
// addresses and monitor flag groups
// ----------------------------------------
`define DEFAULT_SLAVE_ADDR 8'hA2
`define AUX_SLAVE_ADDR 8'hA0
`define ALARM_ROW_FIRST 8'hF8
`define TABLE_ONE 8'h01
`define TABLE_FIVE 8'h05
`define MON34_FLAG_MASK 16'h0F00

`endif

// ===== design/module_config_registers.v
// nonvolatile configuration register bank of the transceiver-module controller
`timescale 1ns/10ps
`include "module_config_defines.vh"

module module_config_registers
(
    // clock and reset
    input wire clock,
    input wire rstn,
    // register access from the serial slave
    input wire [7:0] reg_addr,
    input wire [7:0] reg_table,
    input wire reg_write,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output reg alarm_row_here,
    // serial bus address decision
    output reg [7:0] main_slave_addr,
    output reg aux_memory_enable,
    // pins and internal fault terms
    input wire loss_signal_input,
    input wire loss_low_alarm,
    input wire fault_input_pin,
    input wire transmit_disable_input,
    input wire fet_gate_signal,
    input wire supply_low_alarm,
    input wire supply_above_threshold,
    input wire rate_select_level,
    input wire user_rate_bit,
    output reg loss_signal_output,
    output reg rate_select_output,
    output reg receiver_rate_bit,
    output reg fault_output_pin,
    output reg transmit_disable_output,
    // monitor comparison results, flags per group
    input wire [15:0] alarm_compare,
    input wire [15:0] quick_trip_compare,
    input wire [15:0] warning_compare,
    input wire compare_valid,
    output reg [15:0] alarm_flags,
    output reg [15:0] quick_trip_flags,
    output reg [15:0] warning_flags,
    // monitor conversion control
    input wire [15:0] third_fine_raw,
    input wire [15:0] crossover_value,
    input wire fine_result_valid,
    output reg crossover_enable,
    output reg monitor2_reference_select,
    output reg use_fine_range,
    output reg use_coarse_range,
    output reg auto_range,
    output reg coarse_needed,
    output reg [2:0] first_monitor_shift,
    output reg [2:0] second_monitor_shift,
    output reg [2:0] third_coarse_shift,
    output reg [2:0] third_fine_shift
);

// ----------------------------------------
// configuration storage
// ----------------------------------------
reg [7:0] output_routing_config;
reg [7:0] flag_latch_config;
reg [7:0] disable_and_rssi_config;
reg [7:0] slave_address_value;
reg [7:0] monitor_one_two_shift;
reg [7:0] monitor_three_shift;
reg disable_prev;
reg power_up_window;
reg [7:0] next_rdata;
reg next_loss;
reg next_disable;
reg fault_term;
reg next_fault;
// combinational next values of the address, rate and range outputs
reg next_row_here;
reg [7:0] next_slave_addr;
reg next_aux_enable;
reg next_rate;
reg next_receiver_rate;
reg next_use_fine;
reg next_use_coarse;
reg next_auto_range;
reg next_coarse_needed;
wire disable_event;
wire clear_monitor_flags;

// flag update: follow or hold, with optional clear of monitor 3/4 flags
function [15:0] flag_update;
    input [15:0] current;
    input [15:0] compare;
    input valid;
    input latch;
    input clear_34;
    reg [15:0] updated;
    begin
        updated = current;
        if (valid)
        begin
            updated = latch ? (current | compare) : compare;
        end
        if (clear_34)
        begin
            updated = updated & ~`MON34_FLAG_MASK;
        end
        flag_update = updated;
    end
endfunction

// the previous sample is registered, so a level held high raises one event only
assign disable_event = transmit_disable_input & ~disable_prev;
// one clear term shared by the three flag groups
assign clear_monitor_flags = disable_event & disable_and_rssi_config[`BIT_DISABLE_CLEARS];

// ----------------------------------------
// register access
// ----------------------------------------
// register writes; reserved bits are masked off on the way in
// the reserved byte has no storage, so writes to it simply fall through
always @(posedge clock)
begin
    if (!rstn)
    begin
        output_routing_config <= `RST_OUTPUT_ROUTING;
        flag_latch_config <= `RST_FLAG_LATCH;
        disable_and_rssi_config <= `RST_DISABLE_RSSI;
        slave_address_value <= `RST_SLAVE_ADDRESS;
        monitor_one_two_shift <= `RST_MON12_SHIFT;
        monitor_three_shift <= `RST_THIRD_SHIFT;
    end
    else if (reg_write)
    begin
        case (reg_addr)
            `OFS_OUTPUT_ROUTING: output_routing_config <= reg_wdata;
            `OFS_FLAG_LATCH: flag_latch_config <= reg_wdata & `MASK_FLAG_LATCH;
            `OFS_DISABLE_RSSI: disable_and_rssi_config <= reg_wdata;
            `OFS_SLAVE_ADDRESS: slave_address_value <= reg_wdata;
            `OFS_MON12_SHIFT: monitor_one_two_shift <= reg_wdata & `MASK_SHIFT;
            `OFS_THIRD_SHIFT: monitor_three_shift <= reg_wdata & `MASK_SHIFT;
            default: ;
        endcase
    end
end

// read mux; the reserved byte and unmapped offsets read zero
always @*
begin
    case (reg_addr)
        `OFS_OUTPUT_ROUTING: next_rdata = output_routing_config;
        `OFS_FLAG_LATCH: next_rdata = flag_latch_config;
        `OFS_DISABLE_RSSI: next_rdata = disable_and_rssi_config;
        `OFS_SLAVE_ADDRESS: next_rdata = slave_address_value;
        `OFS_MON12_SHIFT: next_rdata = monitor_one_two_shift;
        `OFS_THIRD_SHIFT: next_rdata = monitor_three_shift;
        default: next_rdata = 8'h00;
    endcase
end

// ----------------------------------------
// pin routing
// ----------------------------------------
always @*
begin
    next_loss = output_routing_config[`BIT_LOSS_SOURCE] ? loss_signal_input : loss_low_alarm;
    next_loss = next_loss ^ output_routing_config[`BIT_LOSS_INVERT];
    fault_term = fault_input_pin ^ output_routing_config[`BIT_FAULT_INVERT];
    next_disable = (disable_and_rssi_config[`BIT_GATE_TO_DISABLE] & fet_gate_signal)
        | (disable_and_rssi_config[`BIT_FAULT_TO_DISABLE] & fault_term)
        | (~disable_and_rssi_config[`BIT_DISABLE_IGNORE] & transmit_disable_input);
    // supply-low alarm counts unless masked while supply is still below threshold
    next_fault = fault_term
        | (supply_low_alarm & ~(output_routing_config[`BIT_SUPPLY_MASK] & power_up_window))
        | (flag_latch_config[`BIT_FAULT_ON_DISABLE] & transmit_disable_input);
end

// power-up window ends once supply rises above the threshold
// limitation: the window never reopens, so a later brown-out is not masked
always @(posedge clock)
begin
    if (!rstn)
    begin
        power_up_window <= 1'b1;
    end
    else if (supply_above_threshold)
    begin
        power_up_window <= 1'b0;
    end
end

// ----------------------------------------
// slave address, row placement and rate
// ----------------------------------------
// the row decision uses the live table number, so a table switch shows on the next cycle
always @*
begin
    next_row_here = 1'b0;
    if (reg_addr >= `ALARM_ROW_FIRST)
    begin
        next_row_here = (reg_table == (output_routing_config[`BIT_ALARM_ROW] ?
            `TABLE_FIVE : `TABLE_ONE));
    end
    // the programmed byte only counts while the source bit selects it
    next_slave_addr = `DEFAULT_SLAVE_ADDR;
    next_aux_enable = 1'b1;
    if (output_routing_config[`BIT_ADDR_SOURCE])
    begin
        next_slave_addr = slave_address_value;
        // the auxiliary page would share the main address, so it steps aside
        next_aux_enable = (slave_address_value != `AUX_SLAVE_ADDR);
    end
    // the receiver bit copies the pin after inversion, as the far end sees it
    next_rate = rate_select_level ^ output_routing_config[`BIT_RATE_INVERT];
    next_receiver_rate = output_routing_config[`BIT_RATE_FROM_PIN] ? next_rate : user_rate_bit;
end

// registered outputs; fault starts high so an unmasked power-up shows a fault
// every output leaves from a flip-flop, one cycle behind its causes
always @(posedge clock)
begin
    if (!rstn)
    begin
        reg_rdata <= 8'h00;
        alarm_row_here <= 1'b0;
        main_slave_addr <= `DEFAULT_SLAVE_ADDR;
        aux_memory_enable <= 1'b1;
        loss_signal_output <= 1'b0;
        rate_select_output <= 1'b0;
        receiver_rate_bit <= 1'b0;
        fault_output_pin <= 1'b1;
        transmit_disable_output <= 1'b0;
        disable_prev <= 1'b0;
    end
    else
    begin
        reg_rdata <= next_rdata;
        // alarm-enable row lives in exactly one table; the other reads empty
        alarm_row_here <= next_row_here;
        main_slave_addr <= next_slave_addr;
        aux_memory_enable <= next_aux_enable;
        loss_signal_output <= next_loss;
        rate_select_output <= next_rate;
        receiver_rate_bit <= next_receiver_rate;
        fault_output_pin <= next_fault;
        transmit_disable_output <= next_disable;
        disable_prev <= transmit_disable_input;
    end
end

// ----------------------------------------
// monitor flags
// ----------------------------------------
// a disable edge clears monitor 3/4 flags after a same-cycle compare
always @(posedge clock)
begin
    if (!rstn)
    begin
        alarm_flags <= 16'h0000;
        quick_trip_flags <= 16'h0000;
        warning_flags <= 16'h0000;
    end
    else
    begin
        alarm_flags <= flag_update(alarm_flags, alarm_compare, compare_valid,
            flag_latch_config[`BIT_ALARM_LATCH], clear_monitor_flags);
        quick_trip_flags <= flag_update(quick_trip_flags, quick_trip_compare, compare_valid,
            flag_latch_config[`BIT_QT_LATCH], clear_monitor_flags);
        warning_flags <= flag_update(warning_flags, warning_compare, compare_valid,
            flag_latch_config[`BIT_WARN_LATCH], clear_monitor_flags);
    end
end

// ----------------------------------------
// conversion control
// ----------------------------------------
// range force decode; 00b and 11b both leave the converter ranging on its own
always @*
begin
    next_use_fine = 1'b0;
    next_use_coarse = 1'b0;
    next_auto_range = 1'b0;
    case (disable_and_rssi_config[1:0])
        `FORCE_FINE: next_use_fine = 1'b1;
        `FORCE_COARSE: next_use_coarse = 1'b1;
        default: next_auto_range = 1'b1;
    endcase
    // raw, unshifted fine result is compared, so the shift setting cannot hide it
    next_coarse_needed = fine_result_valid & disable_and_rssi_config[`BIT_CROSSOVER_EN] &
        (third_fine_raw > crossover_value);
end

// shift counts are copied as stored; reserved bits never reach them
always @(posedge clock)
begin
    if (!rstn)
    begin
        crossover_enable <= 1'b0;
        monitor2_reference_select <= 1'b0;
        use_fine_range <= 1'b0;
        use_coarse_range <= 1'b0;
        auto_range <= 1'b1;
        coarse_needed <= 1'b0;
        first_monitor_shift <= 3'h0;
        second_monitor_shift <= 3'h0;
        third_coarse_shift <= 3'h3;
        third_fine_shift <= 3'h0;
    end
    else
    begin
        crossover_enable <= disable_and_rssi_config[`BIT_CROSSOVER_EN];
        monitor2_reference_select <= disable_and_rssi_config[`BIT_MONITOR_INPUT_TWO_REF];
        use_fine_range <= next_use_fine;
        use_coarse_range <= next_use_coarse;
        auto_range <= next_auto_range;
        coarse_needed <= next_coarse_needed;
        first_monitor_shift <= monitor_one_two_shift[6:4];
        second_monitor_shift <= monitor_one_two_shift[2:0];
        third_coarse_shift <= monitor_three_shift[6:4];
        third_fine_shift <= monitor_three_shift[2:0];
    end
end

endmodule // module_config_registers

// ===== sim/module_config_registers_props.sv
// concurrent checks on the configuration bank ports
`timescale 1ns/10ps
module module_config_registers_props
(
    // clock and reset
    input wire clock,
    input wire rstn,
    // causes
    input wire reg_write,
    input wire rate_select_level,
    input wire transmit_disable_input,
    input wire compare_valid,
    input wire [15:0] warning_compare,
    input wire fine_result_valid,
    input wire [15:0] third_fine_raw,
    input wire [15:0] crossover_value,
    // effects
    input wire [7:0] main_slave_addr,
    input wire aux_memory_enable,
    input wire rate_select_output,
    input wire use_fine_range,
    input wire use_coarse_range,
    input wire auto_range,
    input wire coarse_needed,
    input wire [15:0] alarm_flags,
    input wire [15:0] quick_trip_flags,
    input wire [15:0] warning_flags
);
    // one clock domain; reset aborts every attempt
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    property p_aux; aux_memory_enable == (main_slave_addr != 8'hA0); endproperty
    a_aux: assert property (p_aux)
        else $error("aux memory enable wrong");
    property p_addr; $changed(main_slave_addr) |-> $past(reg_write) || $past(reg_write, 2); endproperty
    a_addr: assert property (p_addr)
        else $error("slave address moved without a write");
    property p_range; $onehot({use_fine_range, use_coarse_range, auto_range}); endproperty
    a_range: assert property (p_range)
        else $error("range mode not one-hot");
    property p_cross; coarse_needed |-> $past(fine_result_valid) && $past(third_fine_raw) > $past(crossover_value);
    endproperty
    a_cross: assert property (p_cross)
        else $error("coarse request without cause");
    // a rate output that moves with quiet inputs means a stuck or wrong path
    property p_rate; (!reg_write && $stable(rate_select_level)) [*2] |=> $stable(rate_select_output); endproperty
    a_rate: assert property (p_rate)
        else $error("rate output moved");
    property p_alarm; $changed(alarm_flags) |->
        $past(compare_valid) || ($past(transmit_disable_input) && !$past(transmit_disable_input, 2)); endproperty
    a_alarm: assert property (p_alarm)
        else $error("alarm flags moved without cause");
    property p_quick; !compare_valid && !transmit_disable_input |=> $stable(quick_trip_flags); endproperty
    a_quick: assert property (p_quick)
        else $error("quick-trip flags moved");
    // monitor 3/4 bits may be cleared by a disable event on the same edge
    property p_warn; compare_valid |=>
        ((warning_flags | 16'h0F00) & $past(warning_compare)) == $past(warning_compare); endproperty
    a_warn: assert property (p_warn)
        else $error("warning flags missed a compare");
endmodule // module_config_registers_props
bind module_config_registers module_config_registers_props module_config_registers_props_i (.clock, .rstn,
    .reg_write, .rate_select_level, .transmit_disable_input, .compare_valid, .warning_compare, .fine_result_valid,
    .third_fine_raw, .crossover_value, .main_slave_addr, .aux_memory_enable, .rate_select_output, .use_fine_range,
    .use_coarse_range, .auto_range, .coarse_needed, .alarm_flags, .quick_trip_flags, .warning_flags);

// ===== sim/reg_host.sv
// host-side model reaching the configuration bank one byte at a time
`timescale 1ns/10ps
module reg_host
(
    // clock
    input wire clock,
    // register port
    input wire [7:0] reg_rdata,
    output reg reg_write = 1'h0,
    output reg [7:0] reg_addr = 8'h00,
    output reg [7:0] reg_wdata = 8'h00
);
    // strobe held to the taking edge, then a quiet cycle so writes never abut
    task wr(input [7:0] a, input [7:0] v);
        reg_addr = a;
        reg_wdata = v;
        reg_write = 1'h1;
        @(posedge clock) #1;
        reg_write = 1'h0;
        reg_wdata = ~v; // released data must not look valid
        @(posedge clock) #1;
    endtask
    // address held until the registered answer has landed
    task rd(input [7:0] a, output [7:0] v);
        reg_addr = a;
        @(posedge clock) #1;
        v = reg_rdata;
    endtask
endmodule // reg_host

// ===== sim/module_config_registers_test.sv
// self-checking testbench for the configuration register bank
`timescale 1ns/10ps
module module_config_registers_test;
    reg clock = 1'h0, rstn = 1'h0, loss_signal_input = 1'h0, loss_low_alarm = 1'h0, fault_input_pin = 1'h0;
    reg transmit_disable_input = 1'h0, fet_gate_signal = 1'h0, supply_low_alarm = 1'h0, user_rate_bit = 1'h0;
    reg supply_above_threshold = 1'h0, rate_select_level = 1'h0, compare_valid = 1'h0, fine_result_valid = 1'h0;
    reg [15:0] alarm_compare = 16'h0000, quick_trip_compare = 16'h0000, warning_compare = 16'h0000;
    reg [15:0] third_fine_raw = 16'h0000, crossover_value = 16'h1000;
    reg [7:0] reg_table = 8'h01, d;
    reg [8:0] k;
    integer n_errors = 0, num_checks = 0;
    wire reg_write, alarm_row_here, aux_memory_enable, loss_signal_output, rate_select_output, receiver_rate_bit;
    wire fault_output_pin, transmit_disable_output, crossover_enable, monitor2_reference_select, use_fine_range;
    wire use_coarse_range, auto_range, coarse_needed;
    wire [7:0] reg_addr, reg_wdata, reg_rdata, main_slave_addr;
    wire [15:0] alarm_flags, quick_trip_flags, warning_flags;
    wire [2:0] first_monitor_shift, second_monitor_shift, third_coarse_shift, third_fine_shift;
    // 40 MHz clock
    initial forever #12.5 clock = ~clock;
    module_config_registers module_config_registers_i (.clock, .rstn, .reg_addr, .reg_table, .reg_write, .reg_wdata,
        .reg_rdata, .alarm_row_here, .main_slave_addr, .aux_memory_enable, .loss_signal_input, .loss_low_alarm,
        .fault_input_pin, .transmit_disable_input, .fet_gate_signal, .supply_low_alarm, .supply_above_threshold,
        .rate_select_level, .user_rate_bit, .loss_signal_output, .rate_select_output, .receiver_rate_bit,
        .fault_output_pin, .transmit_disable_output, .alarm_compare, .quick_trip_compare, .warning_compare,
        .compare_valid, .alarm_flags, .quick_trip_flags, .warning_flags, .third_fine_raw, .crossover_value,
        .fine_result_valid, .crossover_enable, .monitor2_reference_select, .use_fine_range, .use_coarse_range,
        .auto_range, .coarse_needed, .first_monitor_shift, .second_monitor_shift, .third_coarse_shift,
        .third_fine_shift);
    reg_host reg_host_i (.clock, .reg_rdata, .reg_write, .reg_addr, .reg_wdata);
    // ----------------------------------------
    // shared steps
    // ----------------------------------------
    // inputs always change 1 ns after the edge, clear of sampling
    task step;
        @(posedge clock) #1;
    endtask
    task chkv(input [15:0] got, input [15:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task chk1(input got, input exp);
        chkv({15'h0000, got}, {15'h0000, exp});
    endtask
    task wrap_up;
        $display("checks=%0d mismatches=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task do_reset;
        rstn = 1'h0;
        repeat (2) step;
        rstn = 1'h1;
    endtask
    task cmp(input [15:0] v, input [15:0] a, input [15:0] q, input [15:0] w);
        {alarm_compare, quick_trip_compare, warning_compare} = {3{v}};
        compare_valid = 1'h1;
        step;
        compare_valid = 1'h0;
        step;
        chkv(alarm_flags, a);
        chkv(quick_trip_flags, q);
        chkv(warning_flags, w);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // reset values, then all-ones writes; unmapped 90h stays empty
    task t_regs;
        reg [63:0] rv = 64'h8000000000003000, mk = 64'hFF27FFFF00777700;
        for (k = 0; k < 8; k = k + 1)
        begin
            reg_host_i.rd(8'h89 + k[7:0], d);
            chkv({8'h00, d}, {8'h00, rv[63 - 8 * k -: 8]});
            reg_host_i.wr(8'h89 + k[7:0], 8'hFF);
            reg_host_i.rd(8'h89 + k[7:0], d);
            chkv({8'h00, d}, {8'h00, mk[63 - 8 * k -: 8]});
        end
    endtask
    task t_supply;
        supply_low_alarm = 1'h1;
        repeat (2) step;
        chk1(fault_output_pin, 1'h1);
        reg_host_i.wr(8'h89, 8'hC0);
        step;
        chk1(fault_output_pin, 1'h0);
        supply_above_threshold = 1'h1;
        supply_low_alarm = 1'h0;
    endtask
    task t_pins;
        for (k = 0; k < 256; k = k + 1)
        begin
            reg_host_i.wr(8'h89, {k[0], 1'h0, k[1], 2'h0, k[4], k[5], 1'h0});
            {user_rate_bit, rate_select_level, loss_low_alarm, loss_signal_input} = {k[7:6], k[3:2]};
            step;
            chk1(loss_signal_output, (k[0] ? k[2] : k[3]) ^ k[1]);
            chk1(rate_select_output, k[6] ^ k[4]);
            chk1(receiver_rate_bit, k[5] ? k[6] ^ k[4] : k[7]);
        end
    endtask
    task t_disable;
        for (k = 0; k < 256; k = k + 1)
        begin
            reg_host_i.wr(8'h8B, {3'h0, k[0], k[1], k[2], 2'h0});
            reg_host_i.wr(8'h89, {7'h00, k[6]});
            reg_host_i.wr(8'h8A, {2'h0, k[7], 5'h00});
            {transmit_disable_input, fault_input_pin, fet_gate_signal} = k[5:3];
            step;
            chk1(transmit_disable_output,
                k[3] & k[0] | (k[4] ^ k[6]) & k[1] | k[5] & ~k[2]);
            chk1(fault_output_pin, k[4] ^ k[6] | k[7] & k[5]);
        end
        transmit_disable_input = 1'h0;
    endtask
    task t_addr;
        for (k = 0; k < 8; k = k + 1)
        begin
            reg_host_i.wr(8'h8C, k[2] ? 8'hA0 : 8'h55);
            reg_host_i.wr(8'h89, {3'h0, k[1], k[0], 3'h0});
            reg_table = k[1] ? 8'h05 : 8'h01;
            reg_host_i.rd(8'hF8, d);
            chk1(alarm_row_here, k[0] == k[1]);
            chkv({8'h00, main_slave_addr}, k[1] ? (k[2] ? 16'h00A0 : 16'h0055) : 16'h00A2);
            chk1(aux_memory_enable, !(k[1] && k[2]));
            reg_host_i.rd(8'hF7, d);
            chk1(alarm_row_here, 1'h0);
        end
    endtask
    task t_flags;
        reg [15:0] flags_exp;
        reg_host_i.wr(8'h8A, 8'h03);
        cmp(16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF);
        cmp(16'h1234, 16'h1234, 16'hFFFF, 16'hFFFF);
        reg_host_i.wr(8'h8A, 8'h04);
        cmp(16'h0001, 16'h1235, 16'h0001, 16'h0001);
        for (k = 0; k < 2; k = k + 1)
        begin
            reg_host_i.wr(8'h8B, {2'h0, ~k[0], 5'h00});
            transmit_disable_input = 1'h1;
            // the disable event clears monitor 3/4 bits in all three groups alike
            flags_exp = {4'hF, k[0] ? 4'hF : 4'h0, 8'hFF};
            cmp(16'hFFFF, flags_exp, flags_exp, flags_exp);
            transmit_disable_input = 1'h0;
        end
    endtask
    task t_range;
        for (k = 0; k < 4; k = k + 1)
        begin
            reg_host_i.wr(8'h8B, {6'h00, k[1:0]});
            step;
            chkv({13'h0000, auto_range, use_fine_range, use_coarse_range},
                k == 1 ? 16'h0002 : k == 2 ? 16'h0001 : 16'h0004);
        end
        for (k = 0; k < 3; k = k + 1)
        begin
            reg_host_i.wr(8'h8B, k[1] ? 8'h00 : 8'hC0);
            third_fine_raw = 16'h1001 - {15'h0000, k[0]};
            fine_result_valid = 1'h1;
            step;
            fine_result_valid = 1'h0;
            chk1(coarse_needed, k == 0);
            step;
            chk1(coarse_needed, 1'h0);
            chkv({14'h0000, crossover_enable, monitor2_reference_select}, k[1] ? 16'h0000 : 16'h0003);
        end
        reg_host_i.wr(8'h8E, 8'h65);
        reg_host_i.wr(8'h8F, 8'h12);
        chkv({1'h0, first_monitor_shift, 1'h0, second_monitor_shift, 1'h0, third_coarse_shift, 1'h0,
            third_fine_shift}, 16'h6512);
    endtask
    // main sequence; fresh resets before t_regs, t_supply and t_flags keep their starting state known
    initial
    begin
        do_reset;
        t_regs;
        do_reset;
        t_supply;
        t_pins;
        t_disable;
        t_addr;
        do_reset;
        t_flags;
        t_range;
        wrap_up;
    end
    // watchdog well beyond the few thousand cycles the scenarios need
    initial
    begin
        #2000000;
        n_errors = n_errors + 1;
        wrap_up;
    end
endmodule // module_config_registers_test
